// *** inc/fetch_pkg.sv ***
// Constants for the fetch cycle support block: status layout, phase timing.
// Assumes a single 40 MHz system clock; all slower rates are enables.
// Functional notes
// - Fetch address drives sixteen lines in T1, buffers enabled unless hold.
// - Fetch address stays stable from T1 until T4 begins.
// - Eight status bits captured by inverting latches on the status strobe.
// - Fetch status shows opcode fetch, memory read and read-not-write.
// - Status leaves the data bus in T2; bus freed for memory data.
// - Cycle start resets wait latches if slow memory; ready low via phase one.
// - Slow memory only: upper then lower latch set, two periods of wait.
// - Both selects high: lower latch sets in T2, one half-microsecond wait.
// - Slow select held low inhibits internal waits; memory requests its own.
// - Low wait request is synchronised, registered on phase one, holds ready low.
// - First mux stage: memory data when select high, peripheral data when low.
// - Second mux stage: first stage when high, interrupt port when low.
// - Second stage drives bus only while enabled, otherwise floats.
// - Latched input status steers stage one, unless forced input asserted.
// - Latched interrupt-ack status steers stage two, low only in interrupt.
// - Input strobe from T2 phase two to T3 phase two enables the mux.
// - T4 and T5 involve no support logic activity.
// - Status strobe is cycle start coinciding with phase one.
package fetch_pkg;

  // --------------------------------------------------------------------------
  // Clock and phase timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int PHASE_PERIOD_NS = 500;
  localparam int PHI1_WIDTH_NS = 125;
  localparam int PHI2_WIDTH_NS = 250;
  localparam int PHASE_GAP_NS = 32;
  localparam int PHASE_CYCLES = PHASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PHI1_CYCLES = PHI1_WIDTH_NS / CLK_PERIOD_NS;
  localparam int PHI2_CYCLES = PHI2_WIDTH_NS / CLK_PERIOD_NS;
  localparam int GAP_CYCLES = (PHASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHI2_START = PHI1_CYCLES + GAP_CYCLES;
  localparam int PHI2_END = PHI2_START + PHI2_CYCLES;
  localparam int PHASE_COUNT_W = 5;

  // --------------------------------------------------------------------------
  // Bus widths and status byte layout
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ST_INT_ACK_BIT = 0;
  localparam int ST_READ_BIT = 1;
  localparam int ST_STACK_BIT = 2;
  localparam int ST_HLTA_BIT = 3;
  localparam int ST_OUT_BIT = 4;
  localparam int ST_OPCODE_BIT = 5;
  localparam int ST_INPUT_BIT = 6;
  localparam int ST_MEM_READ_BIT = 7;
  localparam logic [7:0] STATUS_INV_RESET = 8'hff;

  // --------------------------------------------------------------------------
  // Processor state tracking
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1 = 3'b001,
    ST_T2 = 3'b010,
    ST_WAIT = 3'b011,
    ST_T3 = 3'b100,
    ST_T45 = 3'b101
  } proc_state_t;

endpackage

// *** hdl/pin_sync.sv ***
// Three-stage synchroniser for pin inputs, one lane per bit.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
module pin_sync
  import fetch_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] stable
);

  // --------------------------------------------------------------------------
  // Per-bit chain; a change counts once stages two and three agree
  // --------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      logic s1, s2, s3, q;
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          s1 <= RESET_VALUE[i];
          s2 <= RESET_VALUE[i];
          s3 <= RESET_VALUE[i];
          q <= RESET_VALUE[i];
        end else begin
          s1 <= raw[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            q <= s3;
          end
        end
      end
      assign stable[i] = q;
    end
  endgenerate

endmodule // pin_sync

// *** hdl/phase_timer.sv ***
// Two-phase clock generator: one-cycle enables marking phase edges.
// Assumes clk_sys at 40 MHz; one phase period is 500 ns.
`timescale 1ns/10ps
module phase_timer
  import fetch_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  output logic phi1_start,
  output logic phi2_start,
  output logic phi2_end
);

  // --------------------------------------------------------------------------
  // Modulo counter over one phase period
  // --------------------------------------------------------------------------
  logic [PHASE_COUNT_W-1:0] count;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (count == PHASE_COUNT_W'(PHASE_CYCLES - 1)) begin
      count <= '0;
    end else begin
      count <= count + PHASE_COUNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phi1_start <= 1'b0;
      phi2_start <= 1'b0;
      phi2_end <= 1'b0;
    end else begin
      phi1_start <= (count == PHASE_COUNT_W'(PHASE_CYCLES - 1));
      phi2_start <= (count == PHASE_COUNT_W'(PHI2_START - 1));
      phi2_end <= (count == PHASE_COUNT_W'(PHI2_END - 1));
    end
  end

endmodule // phase_timer

// *** hdl/fetch_wait_state_input_mux.sv ***
// Fetch cycle support: status latching, wait insertion, input multiplexer.
// Assumes processor, memories and ports are outside clk_sys; pins are synchronised.
`timescale 1ns/10ps
module fetch_wait_state_input_mux
  import fetch_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cycle_start,
  input wire logic hold_active,
  input wire logic [ADDR_W-1:0] proc_address,
  input wire logic [DATA_W-1:0] proc_data_in,
  output logic [DATA_W-1:0] proc_data_out,
  output logic proc_data_oe_n,
  output logic [ADDR_W-1:0] mem_address,
  output logic mem_address_oe_n,
  input wire logic slow_memory_select,
  input wire logic fast_memory_select,
  input wire logic wait_request_n,
  input wire logic forced_input_select_n,
  input wire logic [DATA_W-1:0] memory_data_in,
  input wire logic [DATA_W-1:0] peripheral_data_in,
  input wire logic [DATA_W-1:0] interrupt_instruction,
  output logic status_strobe_n,
  output logic opcode_fetch_status,
  output logic memory_read_status,
  output logic read_not_write_status,
  output logic input_cycle_status,
  output logic interrupt_ack_status,
  output logic processor_ready,
  output logic processor_input_strobe,
  output logic wait_state
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic start_s, hold_s, slow_s, fast_s, wreq_n_s, force_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] pdata_s, mdata_s, periph_s, intport_s;

  pin_sync #(.WIDTH(6), .RESET_VALUE(6'h03)) u_ctrl_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .raw({cycle_start, hold_active, slow_memory_select, fast_memory_select,
          wait_request_n, forced_input_select_n}),
    .stable({start_s, hold_s, slow_s, fast_s, wreq_n_s, force_n_s})
  );

  pin_sync #(.WIDTH(ADDR_W)) u_addr_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .raw(proc_address),
    .stable(addr_s)
  );

  pin_sync #(.WIDTH(DATA_W)) u_bus_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .raw(proc_data_in),
    .stable(pdata_s)
  );

  pin_sync #(.WIDTH(3 * DATA_W)) u_port_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .raw({memory_data_in, peripheral_data_in, interrupt_instruction}),
    .stable({mdata_s, periph_s, intport_s})
  );

  // --------------------------------------------------------------------------
  // Phase enables
  // --------------------------------------------------------------------------
  logic phi1_start, phi2_start, phi2_end;

  phase_timer u_phase (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phi1_start(phi1_start),
    .phi2_start(phi2_start),
    .phi2_end(phi2_end)
  );

  // --------------------------------------------------------------------------
  // Status strobe and status latches
  // --------------------------------------------------------------------------
  logic strobe;
  logic [DATA_W-1:0] status_inv;

  assign strobe = start_s & phi1_start;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_strobe_n <= 1'b1;
    end else begin
      status_strobe_n <= ~strobe;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_inv <= STATUS_INV_RESET;
    end else if (strobe) begin
      status_inv <= ~pdata_s;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      opcode_fetch_status <= 1'b0;
    end else if (strobe) begin
      opcode_fetch_status <= pdata_s[ST_OPCODE_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      memory_read_status <= 1'b0;
    end else if (strobe) begin
      memory_read_status <= pdata_s[ST_MEM_READ_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      read_not_write_status <= 1'b0;
    end else if (strobe) begin
      read_not_write_status <= pdata_s[ST_READ_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      input_cycle_status <= 1'b0;
    end else if (strobe) begin
      input_cycle_status <= pdata_s[ST_INPUT_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      interrupt_ack_status <= 1'b0;
    end else if (strobe) begin
      interrupt_ack_status <= pdata_s[ST_INT_ACK_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Address buffer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_address <= '0;
    end else if (strobe) begin
      mem_address <= addr_s;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_address_oe_n <= 1'b1;
    end else begin
      mem_address_oe_n <= hold_s;
    end
  end

  // --------------------------------------------------------------------------
  // Processor state tracking
  // --------------------------------------------------------------------------
  proc_state_t state, next_state;

  always_comb begin
    next_state = state;
    if (phi1_start) begin
      if (start_s) begin
        next_state = ST_T1;
      end else begin
        case (state)
          ST_T1: next_state = ST_T2;
          ST_T2: next_state = processor_ready ? ST_T3 : ST_WAIT;
          ST_WAIT: next_state = processor_ready ? ST_T3 : ST_WAIT;
          ST_T3: next_state = ST_T45;
          ST_T45: next_state = ST_T45;
          default: next_state = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wait_state <= 1'b0;
    end else begin
      wait_state <= (next_state == ST_WAIT);
    end
  end

  // --------------------------------------------------------------------------
  // Wait latches
  // --------------------------------------------------------------------------
  logic upper_set, lower_set, wait_reset, lower_d;

  assign wait_reset = start_s & slow_s;
  assign lower_d = upper_set | fast_s;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      upper_set <= 1'b1;
    end else if (wait_reset) begin
      upper_set <= 1'b0;
    end else if (phi2_end) begin
      upper_set <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lower_set <= 1'b1;
    end else if (wait_reset) begin
      lower_set <= 1'b0;
    end else if (phi2_end) begin
      lower_set <= lower_d;
    end
  end

  // --------------------------------------------------------------------------
  // Ready re-clocked on phase one
  // --------------------------------------------------------------------------
  logic internal_ready, external_ready;

  assign internal_ready = lower_set;
  assign external_ready = wreq_n_s;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      processor_ready <= 1'b1;
    end else if (phi1_start) begin
      processor_ready <= internal_ready & external_ready;
    end
  end

  // --------------------------------------------------------------------------
  // Input strobe and bus enable
  // --------------------------------------------------------------------------
  logic read_open, read_close;

  function automatic logic bus_quiet(input proc_state_t s);
    return (s == ST_T45) || (s == ST_IDLE) || (s == ST_T1);
  endfunction

  assign read_open = phi2_start && (state == ST_T2) && read_not_write_status;
  assign read_close = phi2_start && (state == ST_T3);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      processor_input_strobe <= 1'b0;
    end else if (read_open) begin
      processor_input_strobe <= 1'b1;
    end else if (read_close || bus_quiet(state)) begin
      processor_input_strobe <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      proc_data_oe_n <= 1'b1;
    end else if (read_open) begin
      proc_data_oe_n <= 1'b0;
    end else if (read_close || bus_quiet(state)) begin
      proc_data_oe_n <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Two-stage input multiplexer
  // --------------------------------------------------------------------------
  logic stage1_sel, stage2_sel;
  logic [DATA_W-1:0] stage1, stage2;

  assign stage1_sel = status_inv[ST_INPUT_BIT] & force_n_s;
  assign stage2_sel = status_inv[ST_INT_ACK_BIT];
  assign stage1 = stage1_sel ? mdata_s : periph_s;
  assign stage2 = stage2_sel ? stage1 : intport_s;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      proc_data_out <= '0;
    end else begin
      proc_data_out <= stage2;
    end
  end

endmodule // fetch_wait_state_input_mux

// *** verification/memory_wait_model.sv ***
// Far-side model: memory data with an access time, external wait requester.
// Assumes the status strobe marks the start of each machine cycle.
`timescale 1ns/10ps
module memory_wait_model #(
  parameter logic [7:0] ACCESS = 8'h18,
  parameter logic [7:0] KEY = 8'h3c
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] mem_address,
  input wire logic status_strobe_n,
  input wire logic [7:0] ext_wait,
  output logic [7:0] memory_data_in,
  output logic wait_request_n
);
  // ----
  // Access timing
  // ----
  logic [7:0] age;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      age <= 8'hff;
      memory_data_in <= 8'h00;
      wait_request_n <= 1'b1;
    end else begin
      if (!status_strobe_n) begin
        age <= 8'h00;
      end else if (age != 8'hff) begin
        age <= age + 8'h01;
      end
      // Data churns until the access time has run out
      memory_data_in <= (age >= ACCESS) ? (mem_address[7:0] ^ KEY) : ~memory_data_in;
      wait_request_n <= !(age < ext_wait);
    end
  end
endmodule // memory_wait_model

// *** verification/fetch_wait_state_input_mux_assertions.sv ***
// Port checker for the fetch support block.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
module fetch_port_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cycle_start,
  input wire logic hold_active,
  input wire logic [15:0] mem_address,
  input wire logic mem_address_oe_n,
  input wire logic proc_data_oe_n,
  input wire logic status_strobe_n,
  input wire logic opcode_fetch_status,
  input wire logic memory_read_status,
  input wire logic read_not_write_status,
  input wire logic input_cycle_status,
  input wire logic interrupt_ack_status,
  input wire logic processor_ready,
  input wire logic processor_input_strobe
);
  // ----
  // Port relations
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_strobe_one_cycle: assert property ($fell(status_strobe_n) |=> status_strobe_n)
    else $error("status strobe wider than one cycle");
  a_strobe_from_start: assert property ($fell(status_strobe_n) |->
    $past(cycle_start, 4) || $past(cycle_start, 5) || $past(cycle_start, 6))
    else $error("status strobe without cycle start");
  a_status_stands: assert property (status_strobe_n |-> $stable({opcode_fetch_status,
    memory_read_status, read_not_write_status, input_cycle_status, interrupt_ack_status,
    mem_address})) else $error("status or address moved between strobes");
  a_status_off_bus: assert property (!status_strobe_n |-> proc_data_oe_n)
    else $error("bus driven during status strobe");
  a_drive_with_strobe: assert property (processor_input_strobe != proc_data_oe_n)
    else $error("bus drive differs from input strobe");
  a_strobe_needs_read: assert property ($rose(processor_input_strobe) |->
    read_not_write_status) else $error("input strobe in a write cycle");
  a_strobe_min_len: assert property ($rose(processor_input_strobe) |=>
    processor_input_strobe [*8]) else $error("input strobe too short");
  a_ready_phase_held: assert property ($changed(processor_ready) |=>
    $stable(processor_ready) [*8]) else $error("ready changed off phase one");
  a_hold_floats_addr: assert property (hold_active [*5] |=> mem_address_oe_n)
    else $error("address driven during hold");
endmodule // fetch_port_checker

bind fetch_wait_state_input_mux fetch_port_checker checker_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .cycle_start(cycle_start),
  .hold_active(hold_active), .mem_address(mem_address), .mem_address_oe_n(mem_address_oe_n),
  .proc_data_oe_n(proc_data_oe_n), .status_strobe_n(status_strobe_n),
  .opcode_fetch_status(opcode_fetch_status), .memory_read_status(memory_read_status),
  .read_not_write_status(read_not_write_status), .input_cycle_status(input_cycle_status),
  .interrupt_ack_status(interrupt_ack_status), .processor_ready(processor_ready),
  .processor_input_strobe(processor_input_strobe)
);

// *** verification/tb_fetch_wait_state_input_mux.sv ***
// Testbench: the bench acts as processor; the model stands for memory.
// Assumes the block's 20-cycle phase period and 3-flop pin synchronisers.
`timescale 1ns/10ps
module tb_fetch_wait_state_input_mux
  import fetch_pkg::*;
;
  localparam logic [7:0] KEY = 8'h3c;
  logic clk_sys, reset_n, cycle_start, hold_active, slow_memory_select, fast_memory_select;
  logic forced_input_select_n, proc_data_oe_n, mem_address_oe_n, wait_request_n;
  logic status_strobe_n, opcode_fetch_status, memory_read_status, read_not_write_status;
  logic input_cycle_status, interrupt_ack_status, processor_ready, processor_input_strobe;
  logic wait_state;
  logic [ADDR_W-1:0] proc_address, mem_address;
  logic [DATA_W-1:0] proc_data_in, proc_data_out, memory_data_in, peripheral_data_in;
  logic [DATA_W-1:0] interrupt_instruction, status_byte, seen;
  logic [7:0] ext_wait;
  int bad_count, comparisons, ticks, waits;

  // Processor bus level: block drives, else status, else its inverse
  assign proc_data_in = !proc_data_oe_n ? proc_data_out : (cycle_start ? status_byte : ~status_byte);

  fetch_wait_state_input_mux dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .cycle_start(cycle_start), .hold_active(hold_active),
    .proc_address(proc_address), .proc_data_in(proc_data_in), .proc_data_out(proc_data_out),
    .proc_data_oe_n(proc_data_oe_n), .mem_address(mem_address),
    .mem_address_oe_n(mem_address_oe_n), .slow_memory_select(slow_memory_select),
    .fast_memory_select(fast_memory_select), .wait_request_n(wait_request_n),
    .forced_input_select_n(forced_input_select_n), .memory_data_in(memory_data_in),
    .peripheral_data_in(peripheral_data_in), .interrupt_instruction(interrupt_instruction),
    .status_strobe_n(status_strobe_n), .opcode_fetch_status(opcode_fetch_status),
    .memory_read_status(memory_read_status), .read_not_write_status(read_not_write_status),
    .input_cycle_status(input_cycle_status), .interrupt_ack_status(interrupt_ack_status),
    .processor_ready(processor_ready), .processor_input_strobe(processor_input_strobe),
    .wait_state(wait_state)
  );

  memory_wait_model #(.KEY(KEY)) mem_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .mem_address(mem_address),
    .status_strobe_n(status_strobe_n), .ext_wait(ext_wait),
    .memory_data_in(memory_data_in), .wait_request_n(wait_request_n)
  );

  // ----
  // Checking and closing
  // ----
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    comparisons++;
    if (got !== want) begin
      bad_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, want);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One machine cycle: status, waits, data returned on the bus
  task automatic run_case(input logic [7:0] st, input logic slow, input logic fast,
    input logic force_n, input logic [7:0] ext, input logic [15:0] addr, input int exp_waits,
    input logic [7:0] exp_data);
    seen = 8'h00;
    waits = 0;
    status_byte <= st;
    slow_memory_select <= slow;
    fast_memory_select <= fast;
    forced_input_select_n <= force_n;
    ext_wait <= ext;
    proc_address <= addr;
    cycle_start <= 1'b1;
    for (int i = 0; i < 40 && status_strobe_n !== 1'b0; i++) @(posedge clk_sys);
    check(status_strobe_n, 1'b0);
    repeat (14) @(posedge clk_sys);
    cycle_start <= 1'b0;
    repeat (110) begin
      @(posedge clk_sys);
      if (wait_state === 1'b1) waits++;
      if (processor_input_strobe === 1'b1) seen = proc_data_out;
    end
    check({opcode_fetch_status, memory_read_status, read_not_write_status,
      input_cycle_status, interrupt_ack_status}, {st[5], st[7], st[1], st[6], st[0]});
    check(mem_address, addr);
    check(mem_address_oe_n, 1'b0);
    check(16'(waits), 16'(exp_waits));
    check(seen, exp_data);
    check({proc_data_oe_n, processor_ready}, 2'b11);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    ticks <= ticks + 1;
    if (ticks == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    reset_n = 1'b0;
    cycle_start = 1'b0;
    hold_active = 1'b0;
    slow_memory_select = 1'b0;
    fast_memory_select = 1'b0;
    forced_input_select_n = 1'b1;
    proc_address = 16'h0000;
    status_byte = 8'h00;
    peripheral_data_in = 8'h96;
    interrupt_instruction = 8'hc7;
    ext_wait = 8'h00;
    bad_count = 0;
    comparisons = 0;
    ticks = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    run_case(8'ha2, 1'b1, 1'b0, 1'b1, 8'h00, 16'h1234, 40, 8'h34 ^ KEY);
    run_case(8'ha2, 1'b1, 1'b1, 1'b1, 8'h00, 16'h00ff, 20, 8'hff ^ KEY);
    run_case(8'ha2, 1'b0, 1'b0, 1'b1, 8'h00, 16'hfffe, 0, 8'hfe ^ KEY);
    run_case(8'ha2, 1'b0, 1'b1, 1'b1, 8'h14, 16'h8001, 20, 8'h01 ^ KEY);
    run_case(8'h42, 1'b0, 1'b0, 1'b1, 8'h00, 16'h4545, 0, 8'h96);
    run_case(8'h23, 1'b0, 1'b0, 1'b1, 8'h00, 16'h0038, 0, 8'hc7);
    run_case(8'ha2, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0a0b, 0, 8'h96);
    run_case(8'h80, 1'b0, 1'b0, 1'b1, 8'h00, 16'h7777, 0, 8'h00);
    hold_active <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(mem_address_oe_n, 1'b1);
    hold_active <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(mem_address_oe_n, 1'b0);
    report_and_stop();
  end
endmodule // tb_fetch_wait_state_input_mux
